// >>> core/pmr_pkg.sv
// Constants of the position range mapping block
package pmr_pkg;
    // ------------------------------------------------------------
    // Parameter indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ACT_SET = 8'h44;
    localparam logic [7:0] IDX_OFFSET = 8'h77;
    localparam logic [7:0] IDX_MAP_END = 8'h78;
    localparam logic [7:0] IDX_LIM_HI = 8'h79;
    localparam logic [7:0] IDX_LIM_LO = 8'h7a;
    localparam logic [7:0] IDX_TARGET = 8'h3c;
    localparam logic [7:0] IDX_PHYS = 8'h3d;

    // ------------------------------------------------------------
    // Geometry and scaling
    // ------------------------------------------------------------
    localparam int STEPS_PER_ROT = 400;
    localparam int SCALE_NUM_DFLT = 400;
    localparam int SCALE_DEN_DFLT = 400;
    localparam int MEAS_ROT = 4032;
    localparam int MARGIN_ROT = 3;
    localparam int USE_ROT = MEAS_ROT - 2 * MARGIN_ROT;
    localparam int MARGIN_STEPS = MARGIN_ROT * STEPS_PER_ROT;
    localparam int SPAN_STEPS = (USE_ROT + MARGIN_ROT) * STEPS_PER_ROT;
    localparam int MAP_END_DFLT_STEPS = (MEAS_ROT / 2) * STEPS_PER_ROT;
    localparam logic signed [31:0] OFFSET_DFLT = 32'sh0;
    localparam logic signed [31:0] POS_DFLT = 32'sh0;

    // Scaled step count, rounded to nearest
    function automatic logic signed [31:0] scale_round(input int steps,
            input int num, input int den);
        longint p;
        p = (longint'(steps) * den + num / 2) / num;
        return p[31:0];
    endfunction
endpackage

// >>> core/pmr_pos_counter.sv
// Absolute position counter fed by measuring-system step pulses
`timescale 1ns/10ps
module pmr_pos_counter
    import pmr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_enc_step,
    input wire logic i_enc_dir,
    output logic signed [31:0] o_pos
);
    logic [1:0] step_sync_q;
    logic [1:0] dir_sync_q;
    logic step_prev_q;
    logic step_edge;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            step_sync_q <= 2'h0;
            dir_sync_q <= 2'h0;
            step_prev_q <= 1'b0;
        end else begin
            step_sync_q <= {step_sync_q[0], i_enc_step};
            dir_sync_q <= {dir_sync_q[0], i_enc_dir};
            step_prev_q <= step_sync_q[1];
        end
    end

    assign step_edge = step_sync_q[1] & ~step_prev_q;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // No motor supply input here: the count never stops for power loss
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_pos <= POS_DFLT;
        end else if (step_edge) begin
            o_pos <= dir_sync_q[1] ? o_pos - 32'sd1 : o_pos + 32'sd1;
        end
    end
endmodule

// >>> core/pmr_range_map.sv
// Position range mapping: offset, mapping end, limits, target check
//
// Notes on behaviour
// - Offset added to every transferred position except the physical one
// - Writing offset parameter sets offset directly
// - Actual-value write: offset = value minus physical
// - Derived offset applies at once, reads back
// - Offset change recomputes all reported positions
// - Position count ignores motor supply loss
// - Three-rotation margin at both range ends
// - Targets inside margins refused with error
// - Factory default mapping end 806400, limits -805200..805200
// - New mapping end recomputes both limits
// - Mapping end 1611600 gives limits 0..1610400
// - Default scaling 400/400, 0.9 degree steps
// - 4032 rotations measured, 4026 usable
// - Limits 4029 and 3 rotations below end
// - Accept end only if actual stays inside
// - End bounded by actual plus scaled constants
// - Changing end places limits 4029 and 3 rotations below the new end
`timescale 1ns/10ps
module pmr_range_map
    import pmr_pkg::*;
#(
    parameter int SCALE_NUM = SCALE_NUM_DFLT,
    parameter int SCALE_DEN = SCALE_DEN_DFLT
)(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_par_wr,
    input wire logic i_par_rd,
    input wire logic [7:0] i_par_index,
    input wire logic [31:0] i_par_wdata,
    input wire logic i_enc_step,
    input wire logic i_enc_dir,
    input wire logic i_move_req,
    output logic o_par_ack,
    output logic o_par_err,
    output logic [31:0] o_par_rdata,
    output logic signed [31:0] o_actual_pos,
    output logic signed [31:0] o_target_pos,
    output logic signed [31:0] o_map_end,
    output logic signed [31:0] o_lim_lo,
    output logic signed [31:0] o_lim_hi,
    output logic o_move_start,
    output logic o_target_err
);
    // Margin and span in user steps, rounded to nearest
    localparam logic signed [31:0] MARGIN_S =
        scale_round(MARGIN_STEPS, SCALE_NUM, SCALE_DEN);
    localparam logic signed [31:0] SPAN_S =
        scale_round(SPAN_STEPS, SCALE_NUM, SCALE_DEN);
    localparam logic signed [31:0] MAP_END_DFLT =
        scale_round(MAP_END_DFLT_STEPS, SCALE_NUM, SCALE_DEN);

    logic signed [31:0] phys_pos;
    logic signed [31:0] offset_q;
    logic signed [31:0] end_raw_q;
    logic signed [31:0] lo_raw_q;
    logic signed [31:0] hi_raw_q;
    logic signed [31:0] tgt_raw_q;
    logic signed [31:0] wr_raw;
    logic signed [31:0] new_lo;
    logic signed [31:0] new_hi;
    logic wr_end;
    logic end_ok;
    logic lim_ok;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------
    // Physical position
    // ------------------------------------------------------------
    pmr_pos_counter u_counter (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_enc_step(i_enc_step),
        .i_enc_dir(i_enc_dir),
        .o_pos(phys_pos)
    );

    // ------------------------------------------------------------
    // Decode and range checks
    // ------------------------------------------------------------
    function automatic logic idx_known(input logic [7:0] idx);
        return idx == IDX_ACT_SET || idx == IDX_OFFSET ||
            idx == IDX_MAP_END || idx == IDX_LIM_HI ||
            idx == IDX_LIM_LO || idx == IDX_TARGET || idx == IDX_PHYS;
    endfunction

    // Internal values are kept offset-free so an offset change
    // moves every reported value at once without rewriting them
    assign wr_raw = $signed(i_par_wdata) - offset_q;
    assign new_lo = wr_raw - SPAN_S;
    assign new_hi = wr_raw - MARGIN_S;
    // One step of slack absorbs rounding of the scaled constants
    assign end_ok = (phys_pos >= new_lo - 32'sd1) &&
        (phys_pos <= new_hi + 32'sd1);
    assign lim_ok = (wr_raw >= end_raw_q - SPAN_S) &&
        (wr_raw <= end_raw_q - MARGIN_S);
    assign wr_end = i_par_wr && i_par_index == IDX_MAP_END && end_ok;
    assign wr_hit = i_par_wr && idx_known(i_par_index) &&
        i_par_index != IDX_PHYS &&
        (i_par_index != IDX_MAP_END || end_ok) &&
        ((i_par_index != IDX_LIM_HI && i_par_index != IDX_LIM_LO) ||
        lim_ok);
    assign rd_hit = i_par_rd && idx_known(i_par_index);

    // ------------------------------------------------------------
    // Offset
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            offset_q <= OFFSET_DFLT;
        end else if (i_par_wr && i_par_index == IDX_OFFSET) begin
            offset_q <= $signed(i_par_wdata);
        end else if (i_par_wr && i_par_index == IDX_ACT_SET) begin
            offset_q <= $signed(i_par_wdata) - phys_pos;
        end
    end

    // ------------------------------------------------------------
    // Mapping end and limits
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            end_raw_q <= MAP_END_DFLT;
            lo_raw_q <= MAP_END_DFLT - SPAN_S;
            hi_raw_q <= MAP_END_DFLT - MARGIN_S;
        end else if (wr_end) begin
            end_raw_q <= wr_raw;
            lo_raw_q <= new_lo;
            hi_raw_q <= new_hi;
        end else if (wr_hit && i_par_index == IDX_LIM_HI) begin
            hi_raw_q <= wr_raw;
        end else if (wr_hit && i_par_index == IDX_LIM_LO) begin
            lo_raw_q <= wr_raw;
        end
    end

    // ------------------------------------------------------------
    // Target and move start
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tgt_raw_q <= POS_DFLT;
        end else if (i_par_wr && i_par_index == IDX_TARGET) begin
            tgt_raw_q <= wr_raw;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_move_start <= 1'b0;
            o_target_err <= 1'b0;
        end else begin
            o_move_start <= i_move_req && tgt_raw_q >= lo_raw_q &&
                tgt_raw_q <= hi_raw_q;
            o_target_err <= i_move_req && (tgt_raw_q < lo_raw_q ||
                tgt_raw_q > hi_raw_q);
        end
    end

    // ------------------------------------------------------------
    // Reported values
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_actual_pos <= POS_DFLT;
            o_target_pos <= POS_DFLT;
            o_map_end <= MAP_END_DFLT;
            o_lim_lo <= MAP_END_DFLT - SPAN_S;
            o_lim_hi <= MAP_END_DFLT - MARGIN_S;
        end else begin
            o_actual_pos <= phys_pos + offset_q;
            o_target_pos <= tgt_raw_q + offset_q;
            o_map_end <= end_raw_q + offset_q;
            o_lim_lo <= lo_raw_q + offset_q;
            o_lim_hi <= hi_raw_q + offset_q;
        end
    end

    // ------------------------------------------------------------
    // Parameter access answer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_par_ack <= 1'b0;
            o_par_err <= 1'b0;
            o_par_rdata <= 32'h0;
        end else begin
            o_par_ack <= i_par_wr | i_par_rd;
            o_par_err <= (i_par_wr && !wr_hit) || (i_par_rd && !rd_hit);
            if (i_par_rd) begin
                case (i_par_index)
                    IDX_OFFSET: o_par_rdata <= offset_q;
                    IDX_ACT_SET: o_par_rdata <= phys_pos + offset_q;
                    IDX_MAP_END: o_par_rdata <= end_raw_q + offset_q;
                    IDX_LIM_HI: o_par_rdata <= hi_raw_q + offset_q;
                    IDX_LIM_LO: o_par_rdata <= lo_raw_q + offset_q;
                    IDX_TARGET: o_par_rdata <= tgt_raw_q + offset_q;
                    IDX_PHYS: o_par_rdata <= phys_pos;
                    default: o_par_rdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_offset_direct: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) i_par_wr && i_par_index == IDX_OFFSET
        |=> offset_q == $past(i_par_wdata))
        else $error("offset write not adopted");
    chk_offset_derived: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) i_par_wr && i_par_index == IDX_ACT_SET
        |=> offset_q == $past(i_par_wdata) - $past(phys_pos))
        else $error("derived offset wrong");
    chk_actual_offset: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) ##1 1'b1 |->
        o_actual_pos == $past(phys_pos) + $past(offset_q))
        else $error("actual position lacks offset");
    chk_offset_readback: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) i_par_rd && i_par_index == IDX_OFFSET
        |=> o_par_rdata == $past(offset_q))
        else $error("offset readback wrong");
    chk_end_recompute: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) $changed(offset_q) |=>
        o_map_end == $past(end_raw_q) + $past(offset_q))
        else $error("mapping end not recomputed");
    chk_limit_span: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) wr_end |=> hi_raw_q == end_raw_q - 32'sd1200
        && lo_raw_q == end_raw_q - 32'sd1611600)
        else $error("limits not placed from end");
    chk_end_bounds: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) i_par_wr && i_par_index == IDX_MAP_END &&
        (wr_raw < phys_pos + MARGIN_S - 32'sd1 ||
        wr_raw > phys_pos + SPAN_S + 32'sd1)
        |=> $stable(end_raw_q) && o_par_err)
        else $error("out-of-range end accepted");
    chk_target_refuse: assert property (@(posedge i_ref_clk)
        disable iff (i_srst) i_move_req && tgt_raw_q > hi_raw_q
        |=> o_target_err && !o_move_start)
        else $error("target in margin not refused");
    chk_default_state: assert property (@(posedge i_ref_clk)
        $fell(i_srst) |-> end_raw_q == 32'sd806400 &&
        lo_raw_q == -32'sd805200 && hi_raw_q == 32'sd805200)
        else $error("factory defaults wrong");

    cov_offset_write: cover property (@(posedge i_ref_clk)
        i_par_wr && i_par_index == IDX_OFFSET);
    cov_actual_write: cover property (@(posedge i_ref_clk)
        i_par_wr && i_par_index == IDX_ACT_SET);
    cov_end_accept: cover property (@(posedge i_ref_clk) wr_end);
    cov_target_err: cover property (@(posedge i_ref_clk) o_target_err);
endmodule

// >>> testbench/pmr_fieldbus_master.sv
// Fieldbus master model issuing parameter accesses
`timescale 1ns/10ps
module pmr_fieldbus_master (
    input wire logic i_ref_clk,
    input wire logic i_par_ack,
    input wire logic i_par_err,
    input wire logic [31:0] i_par_rdata,
    output logic o_par_wr,
    output logic o_par_rd,
    output logic [7:0] o_par_index,
    output logic [31:0] o_par_wdata
);
    // ------------------------------------------------------------
    // Access
    // ------------------------------------------------------------
    initial begin
        o_par_wr = 1'b0;
        o_par_rd = 1'b0;
        o_par_index = 8'h0;
        o_par_wdata = 32'h0;
    end

    // Released index and data are inverted so a stale value never
    // passes for a held one
    task automatic access(input logic wr, input logic [7:0] idx,
            input logic [31:0] data, output logic ok, output logic err,
            output logic [31:0] rdata);
        int n;
        ok = 1'b0;
        err = 1'b0;
        rdata = 32'h0;
        @(posedge i_ref_clk);
        o_par_wr <= wr;
        o_par_rd <= !wr;
        o_par_index <= idx;
        o_par_wdata <= data;
        @(posedge i_ref_clk);
        o_par_wr <= 1'b0;
        o_par_rd <= 1'b0;
        o_par_index <= ~idx;
        o_par_wdata <= ~data;
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge i_ref_clk);
            if (i_par_ack === 1'b1) begin
                ok = 1'b1;
                err = i_par_err;
                rdata = i_par_rdata;
            end
        end
    endtask
endmodule

// >>> testbench/position_range_mapping_test.sv
// Self-checking testbench of the position range mapping block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module position_range_mapping_test
    import pmr_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int END_D = MAP_END_DFLT_STEPS;
    logic clk = 1'b0, srst = 1'b1, step = 1'b0, dir = 1'b0, mreq = 1'b0;
    logic wr, rd, ack, err, mstart, terr;
    logic [7:0] idx;
    logic [31:0] wdata, rdata;
    logic signed [31:0] act, tgt, mend, llo, lhi;
    int num_errors = 0;
    int compares = 0;

    always #10 clk = ~clk;

    pmr_fieldbus_master i_master (.i_ref_clk(clk), .i_par_ack(ack),
        .i_par_err(err), .i_par_rdata(rdata), .o_par_wr(wr),
        .o_par_rd(rd), .o_par_index(idx), .o_par_wdata(wdata));

    pmr_range_map #(.SCALE_NUM(SCALE_NUM_DFLT), .SCALE_DEN(SCALE_DEN_DFLT))
    i_dut (.i_ref_clk(clk), .i_srst(srst), .i_par_wr(wr), .i_par_rd(rd),
        .i_par_index(idx), .i_par_wdata(wdata), .i_enc_step(step),
        .i_enc_dir(dir), .i_move_req(mreq), .o_par_ack(ack),
        .o_par_err(err), .o_par_rdata(rdata), .o_actual_pos(act),
        .o_target_pos(tgt), .o_map_end(mend), .o_lim_lo(llo),
        .o_lim_hi(lhi), .o_move_start(mstart), .o_target_err(terr));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic put(input logic [7:0] i, input int d, input logic ee);
        logic ok, e;
        logic [31:0] r;
        i_master.access(1'b1, i, d, ok, e, r);
        `CHK(ok, 1'b1);
        `CHK(e, ee);
        repeat (2) @(posedge clk);
    endtask

    task automatic get(input logic [7:0] i, input int d);
        logic ok, e;
        logic [31:0] r;
        i_master.access(1'b0, i, 32'h0, ok, e, r);
        `CHK(ok, 1'b1);
        `CHK(e, 1'b0);
        `CHK(r, d);
    endtask

    // Stored target is checked; exactly one of the two answers expected
    task automatic move(input int t, input logic go);
        logic s, e;
        put(IDX_TARGET, t, 1'b0);
        s = 1'b0;
        e = 1'b0;
        @(posedge clk);
        mreq <= 1'b1;
        @(posedge clk);
        mreq <= 1'b0;
        repeat (3) begin
            @(posedge clk);
            s = s | mstart;
            e = e | terr;
        end
        `CHK(s, go);
        `CHK(e, !go);
    endtask

    // Pulses kept three cycles each, above the synchroniser minimum
    task automatic steps(input int n, input logic d);
        dir <= d;
        repeat (n) begin
            repeat (3) @(posedge clk);
            step <= 1'b1;
            repeat (3) @(posedge clk);
            step <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(mend, END_D);
        `CHK(llo, END_D - SPAN_STEPS);
        `CHK(lhi, END_D - MARGIN_STEPS);
        get(IDX_OFFSET, 0);
        move(END_D - MARGIN_STEPS + 1, 1'b0);
        move(END_D - SPAN_STEPS, 1'b1);
        put(IDX_MAP_END, MARGIN_STEPS - 2, 1'b1);
        put(IDX_MAP_END, SPAN_STEPS + 2, 1'b1);
        `CHK(mend, END_D);
        put(IDX_LIM_HI, 32'h3e8, 1'b0);
        `CHK(lhi, 32'sh3e8);
        put(IDX_LIM_LO, -1000, 1'b0);
        `CHK(llo, -32'sh3e8);
        put(IDX_LIM_HI, END_D, 1'b1);
        `CHK(lhi, 32'sh3e8);
        put(IDX_MAP_END, SPAN_STEPS, 1'b0);
        `CHK(mend, SPAN_STEPS);
        `CHK(llo, 0);
        `CHK(lhi, SPAN_STEPS - MARGIN_STEPS);
        move(-1, 1'b0);
        move(SPAN_STEPS - MARGIN_STEPS, 1'b1);
        put(IDX_OFFSET, 32'h3e8, 1'b0);
        `CHK(act, 32'sh3e8);
        `CHK(tgt, SPAN_STEPS - MARGIN_STEPS + 1000);
        `CHK(mend, SPAN_STEPS + 1000);
        `CHK(llo, 32'sh3e8);
        get(IDX_MAP_END, SPAN_STEPS + 1000);
        steps(5, 1'b0);
        `CHK(act, 32'sh3ed);
        steps(2, 1'b1);
        get(IDX_PHYS, 3);
        put(IDX_ACT_SET, 0, 1'b0);
        get(IDX_OFFSET, -3);
        get(IDX_ACT_SET, 0);
        `CHK(act, 32'sh0);
        `CHK(mend, SPAN_STEPS - 3);
        put(IDX_PHYS, 7, 1'b1);
        put(8'h00, 0, 1'b1);
        wrap_up();
    end

    // Whole sequence needs about 185 cycles
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
